// ==== inc/sca_defines.svh ====
// address map and status word layout
`ifndef SCA_DEFINES_SVH
`define SCA_DEFINES_SVH

// ----------------------------------------
// local i/o addresses
// ----------------------------------------
`define SCA_ADDR_ID_VECTOR   16'h0480
`define SCA_ADDR_LOCAL_PAGE  16'h0482
`define SCA_ADDR_CSW         16'h0484
`define SCA_ADDR_BUS_RESET   16'h0486
`define SCA_ADDR_CLR_BASE    16'h0488
`define SCA_ADDR_CHIP_IRQ_RD 16'h040d
`define SCA_ADDR_IN_PAGE     16'h04a2
`define SCA_ADDR_OUT_PAGE    16'h04c2
`define SCA_ADDR_HOST_FRST   16'h0500
`define SCA_ADDR_TGT_FRST    16'h0580
`define SCA_ADDR_FIFO_WORD   16'h0600
`define SCA_ADDR_FIFO_BYTE   16'h0608

// ----------------------------------------
// control status word bit positions
// ----------------------------------------
`define SCA_BIT_WPTR     15
`define SCA_BIT_RPTR     14
`define SCA_BIT_BEMPTY   13
`define SCA_BIT_BFULL    12
`define SCA_BIT_WFULL1_N 11
`define SCA_BIT_WFULL0_N 10
`define SCA_BIT_WAVAIL1  9
`define SCA_BIT_WAVAIL0  8
`define SCA_BIT_HIRQ_N   7
`define SCA_BIT_CHIP_N   6
`define SCA_BIT_NMI_N    5
`define SCA_BIT_EOPB_N   4
`define SCA_BIT_EOPA_N   3
`define SCA_BIT_BRST_N   2
`define SCA_BIT_ATTN     1
`define SCA_BIT_PRECFG   0
`define SCA_CSW_LOW_RST  8'hfc

// ----------------------------------------
// controller command port
// ----------------------------------------
`define SCA_SW_CMD       4'h0
`define SCA_SW_ADDR      4'h1
`define SCA_SW_DATA      4'h2
`define SCA_SW_STAT      4'h3
`define SCA_INIT_LAST    3'h5
`define SCA_FIFO_DEPTH   16

`endif

// ==== inc/sca_pkg.sv ====
// shared types of both ends
`default_nettype none
package sca_pkg;

    typedef enum logic [2:0] {
        OP_RAW_WR  = 3'b000,
        OP_RAW_RD  = 3'b001,
        OP_WORD_WR = 3'b010,
        OP_WORD_RD = 3'b011,
        OP_BYTE_WR = 3'b100,
        OP_BYTE_RD = 3'b101
    } sca_op_type;

    typedef enum logic [2:0] {
        ST_INIT     = 3'b000,
        ST_IDLE     = 3'b001,
        ST_CHECK    = 3'b010,
        ST_CHK_WAIT = 3'b011,
        ST_CHK_EVAL = 3'b100,
        ST_ISSUE    = 3'b101,
        ST_ISS_WAIT = 3'b110,
        ST_ISS_CAPT = 3'b111
    } sca_host_state_type;

    typedef struct packed {
        logic        wptr;
        logic        rptr;
        logic [7:0]  low;
        logic [15:0] rdata;
        logic [15:0] id_vector;
        logic [6:0]  local_page;
        logic [6:0]  in_page;
        logic [6:0]  out_page;
        logic        bus_reset;
        logic [4:0]  irq;
    } sca_dev_state_type;

    typedef struct packed {
        sca_host_state_type st;
        logic [2:0]  op;
        logic [15:0] addr;
        logic [15:0] data;
        logic [15:0] result;
        logic        busy;
        logic        refused;
        logic        done;
        logic        init_done;
        logic [2:0]  init_idx;
        logic [15:0] sw_rdata;
        logic [15:0] lb_addr;
        logic [15:0] lb_wdata;
        logic        lb_wr;
        logic        lb_rd;
    } sca_host_regs_type;

endpackage
`default_nettype wire

// ==== inc/sca_local_if.sv ====
// local i/o bus between the ends
`default_nettype none
interface sca_local_if;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;

    modport dev (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// ==== rtl/sca_byte_fifo.sv ====
// one byte-wide fifo with flush
`default_nettype none
module sca_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             flush,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] din,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] dout,
    output logic                  full,
    output logic                  empty
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wi;
        logic [AW-1:0]               ri;
        logic [AW:0]                 cnt;
    } sca_fifo_state_type;

    sca_fifo_state_type r;
    sca_fifo_state_type next_r;
    logic               do_push;
    logic               do_pop;

    assign full  = (r.cnt == (AW+1)'(DEPTH));
    assign empty = (r.cnt == '0);
    assign dout  = r.mem[r.ri];

    always_comb
    begin
        next_r  = r;
        do_push = push && !full;
        do_pop  = pop && !empty;
        if (ce)
        begin
            if (flush)
            begin
                next_r.wi  = '0;
                next_r.ri  = '0;
                next_r.cnt = '0;
            end
            else
            begin
                if (do_push)
                begin
                    next_r.mem[r.wi] = din;
                    next_r.wi        = r.wi + 1'b1;
                end
                if (do_pop)
                    next_r.ri = r.ri + 1'b1;
                next_r.cnt = r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            r <= '0;
        else
            r <= next_r;
    end
endmodule // sca_byte_fifo
`default_nettype wire

// ==== rtl/sca_host.sv ====
// controller end: local bus master on software command
`default_nettype none
`include "sca_defines.svh"
module sca_host import sca_pkg::*; (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [3:0]  sw_addr,
    input  wire logic [15:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [15:0] sw_rdata,
    sca_local_if.host        lb
);
    sca_host_regs_type r;
    sca_host_regs_type next_r;
    logic              ok;

    assign sw_rdata = r.sw_rdata;
    assign lb.addr  = r.lb_addr;
    assign lb.wdata = r.lb_wdata;
    assign lb.wr    = r.lb_wr;
    assign lb.rd    = r.lb_rd;

    // ----------------------------------------
    // command sequencer
    // ----------------------------------------
    always_comb
    begin
        next_r = r;
        ok     = 1'b0;
        if (ce)
        begin
            next_r.lb_wr    = 1'b0;
            next_r.lb_rd    = 1'b0;
            next_r.sw_rdata = '0;
            if (sw_rd)
            begin
                case (sw_addr)
                    `SCA_SW_STAT: next_r.sw_rdata = {12'h000, r.init_done, r.refused,
                                                     r.done, r.busy};
                    `SCA_SW_DATA: next_r.sw_rdata = r.result;
                    `SCA_SW_ADDR: next_r.sw_rdata = r.addr;
                    default:      next_r.sw_rdata = '0;
                endcase
            end
            if (sw_wr && sw_addr == `SCA_SW_ADDR)
                next_r.addr = sw_wdata;
            if (sw_wr && sw_addr == `SCA_SW_DATA)
                next_r.data = sw_wdata;
            case (r.st)
                ST_INIT:
                begin
                    // clear undefined bits 5..0
                    next_r.lb_wr    = 1'b1;
                    next_r.lb_addr  = `SCA_ADDR_CLR_BASE + 16'(r.init_idx);
                    next_r.lb_wdata = '0;
                    next_r.init_idx = r.init_idx + 3'h1;
                    if (r.init_idx == `SCA_INIT_LAST)
                    begin
                        next_r.st        = ST_IDLE;
                        next_r.busy      = 1'b0;
                        next_r.init_done = 1'b1;
                    end
                end
                ST_IDLE:
                begin
                    if (sw_wr && sw_addr == `SCA_SW_CMD)
                    begin
                        next_r.op      = sw_wdata[2:0];
                        next_r.busy    = 1'b1;
                        next_r.done    = 1'b0;
                        next_r.refused = 1'b0;
                        if (sw_wdata[2:1] == 2'b00)
                            next_r.st = ST_ISSUE;
                        else
                            next_r.st = ST_CHECK;
                    end
                end
                ST_CHECK:
                begin
                    next_r.lb_rd   = 1'b1;
                    next_r.lb_addr = `SCA_ADDR_CSW;
                    next_r.st      = ST_CHK_WAIT;
                end
                ST_CHK_WAIT:
                    next_r.st = ST_CHK_EVAL;
                ST_CHK_EVAL:
                begin
                    case (r.op)
                        OP_BYTE_RD: ok = !lb.rdata[`SCA_BIT_BEMPTY];
                        OP_BYTE_WR: ok = !lb.rdata[`SCA_BIT_BFULL];
                        OP_WORD_WR: ok = lb.rdata[`SCA_BIT_WFULL1_N]
                                         && lb.rdata[`SCA_BIT_WFULL0_N];
                        OP_WORD_RD: ok = lb.rdata[`SCA_BIT_WAVAIL1]
                                         && lb.rdata[`SCA_BIT_WAVAIL0];
                        default:    ok = 1'b1;
                    endcase
                    if (ok)
                        next_r.st = ST_ISSUE;
                    else
                    begin
                        next_r.st      = ST_IDLE;
                        next_r.refused = 1'b1;
                        next_r.done    = 1'b1;
                        next_r.busy    = 1'b0;
                    end
                end
                ST_ISSUE:
                begin
                    next_r.lb_wdata = r.data;
                    case (r.op[2:1])
                        2'b01:   next_r.lb_addr = `SCA_ADDR_FIFO_WORD;
                        2'b10:   next_r.lb_addr = `SCA_ADDR_FIFO_BYTE;
                        default: next_r.lb_addr = r.addr;
                    endcase
                    if (r.op[0])
                    begin
                        next_r.lb_rd = 1'b1;
                        next_r.st    = ST_ISS_WAIT;
                    end
                    else
                    begin
                        next_r.lb_wr = 1'b1;
                        next_r.st    = ST_IDLE;
                        next_r.done  = 1'b1;
                        next_r.busy  = 1'b0;
                    end
                end
                ST_ISS_WAIT:
                    next_r.st = ST_ISS_CAPT;
                ST_ISS_CAPT:
                begin
                    next_r.result = lb.rdata;
                    next_r.st     = ST_IDLE;
                    next_r.done   = 1'b1;
                    next_r.busy   = 1'b0;
                end
                default:
                    next_r.st = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            r      <= '0;
            r.st   <= ST_INIT;
            r.busy <= 1'b1;
        end
        else
            r <= next_r;
    end
endmodule // sca_host
`default_nettype wire

// ==== rtl/sca_dev.sv ====
// adapter end: status word, pages and fifos
// ----------------------------------------
// Notes on behaviour
// - write pointer toggles per byte write; select two zeroes
// - read pointer toggles per byte read; select three zeroes
// - bit 13: fifo at read pointer empty
// - bit 12: fifo at write pointer full
// - bits 11,10: word side full, active low
// - bits 9,8: word bytes available, low when empty
// - bit 7 drives host request; ack/reset/0x048f negate
// - bit 6 latches chip irq; chip register read clears
// - bit 5 nmi on dma fault; 0x048d clears
// - bits 4,3 end of process; 0x048c/0x048b clear
// - bit 2 bus reset; clear loses while condition
// - bit 1 attention set by host; 0x0489 clears
// - bit 0 set by id access outside an iack cycle; 0x0488 clears
// - firmware clears bits 5..0 after power up
// - one 16-bit status word read at 0x0484
// - three write-only 7-bit page registers: local, inbound and outbound
// - word access to both fifos at 0x0600
// ----------------------------------------
//
// The plain strobed port was left to the implementer.
`default_nettype none
`include "sca_defines.svh"
module sca_dev import sca_pkg::*; #(
    parameter int FIFO_DEPTH = `SCA_FIFO_DEPTH
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        sys_ctrl_access,
    input  wire logic        sys_idvec_access,
    input  wire logic        sys_iack_cycle,
    input  wire logic        interrupt_ack_strobe,
    input  wire logic        chip_irq,
    input  wire logic        dma_fault,
    input  wire logic        eop_a,
    input  wire logic        eop_b,
    input  wire logic        scsi_rst_detect,
    output logic             host_irq_request_n,
    output logic             local_irq_zero,
    output logic             local_irq_one,
    output logic             local_irq_two,
    output logic             local_irq_three,
    output logic             local_nmi,
    output logic      [15:0] id_vector,
    output logic      [6:0]  local_page,
    output logic      [6:0]  inbound_page,
    output logic      [6:0]  outbound_page,
    output logic             bus_reset_strobe,
    sca_local_if.dev         lb
);
    sca_dev_state_type r;
    sca_dev_state_type next_r;
    logic [1:0]        push;
    logic [1:0]        pop;
    logic [1:0][7:0]   din;
    logic [1:0][7:0]   dout;
    logic [1:0]        full;
    logic [1:0]        empty;
    logic              flush;
    logic              word_wr;
    logic              word_rd;
    logic              byte_wr;
    logic              byte_rd;
    logic [15:0]       stat;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic hit(input logic [15:0] a);
        return (lb.wr || lb.rd) && (lb.addr == a);
    endfunction

    function automatic logic clr(input int b);
        return hit(`SCA_ADDR_CLR_BASE + 16'(b));
    endfunction

    always_comb flush = hit(`SCA_ADDR_HOST_FRST) || hit(`SCA_ADDR_TGT_FRST);
    assign word_wr = lb.wr && lb.addr == `SCA_ADDR_FIFO_WORD;
    assign word_rd = lb.rd && lb.addr == `SCA_ADDR_FIFO_WORD;
    assign byte_wr = lb.wr && lb.addr == `SCA_ADDR_FIFO_BYTE;
    assign byte_rd = lb.rd && lb.addr == `SCA_ADDR_FIFO_BYTE;

    // ----------------------------------------
    // fifo pair
    // ----------------------------------------
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_fifo
            assign push[g] = word_wr || (byte_wr && r.wptr == 1'(g));
            assign pop[g]  = word_rd || (byte_rd && r.rptr == 1'(g));
            assign din[g]  = word_wr ? lb.wdata[8*g +: 8] : lb.wdata[7:0];

            sca_byte_fifo #(
                .WIDTH (8),
                .DEPTH (FIFO_DEPTH)
            ) u_fifo (
                .clk_sys (clk_sys),
                .rst     (rst),
                .ce      (ce),
                .flush   (flush),
                .push    (push[g]),
                .din     (din[g]),
                .pop     (pop[g]),
                .dout    (dout[g]),
                .full    (full[g]),
                .empty   (empty[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // status word
    // ----------------------------------------
    always_comb
    begin
        stat                    = '0;
        stat[`SCA_BIT_WPTR]     = r.wptr;
        stat[`SCA_BIT_RPTR]     = r.rptr;
        stat[`SCA_BIT_BEMPTY]   = empty[r.rptr];
        stat[`SCA_BIT_BFULL]    = full[r.wptr];
        stat[`SCA_BIT_WFULL1_N] = !full[1];
        stat[`SCA_BIT_WFULL0_N] = !full[0];
        stat[`SCA_BIT_WAVAIL1]  = !empty[1];
        stat[`SCA_BIT_WAVAIL0]  = !empty[0];
        stat[7:0]               = r.low;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        next_r = r;
        if (ce)
        begin
            next_r.rdata = '0;
            if (lb.rd)
            begin
                case (lb.addr)
                    `SCA_ADDR_CSW:       next_r.rdata = stat;
                    `SCA_ADDR_FIFO_WORD: next_r.rdata = {dout[1], dout[0]};
                    `SCA_ADDR_FIFO_BYTE: next_r.rdata = {8'h00, dout[r.rptr]};
                    default:             next_r.rdata = '0;
                endcase
            end
            if (byte_wr)
                next_r.wptr = !r.wptr;
            if (hit(`SCA_ADDR_TGT_FRST))
                next_r.wptr = 1'b0;
            if (byte_rd)
                next_r.rptr = !r.rptr;
            if (hit(`SCA_ADDR_HOST_FRST))
                next_r.rptr = 1'b0;
            if (lb.wr)
            begin
                case (lb.addr)
                    `SCA_ADDR_ID_VECTOR:  next_r.id_vector  = lb.wdata;
                    `SCA_ADDR_LOCAL_PAGE: next_r.local_page = lb.wdata[6:0];
                    `SCA_ADDR_IN_PAGE:    next_r.in_page    = lb.wdata[6:0];
                    `SCA_ADDR_OUT_PAGE:   next_r.out_page   = lb.wdata[6:0];
                    `SCA_ADDR_BUS_RESET:  next_r.bus_reset  = lb.wdata[0];
                    default:              next_r.bus_reset  = r.bus_reset;
                endcase
            end
            // host request: firmware write wins
            if (interrupt_ack_strobe || clr(`SCA_BIT_HIRQ_N))
                next_r.low[`SCA_BIT_HIRQ_N] = 1'b1;
            if (lb.wr && lb.addr == `SCA_ADDR_CSW)
                next_r.low[`SCA_BIT_HIRQ_N] = lb.wdata[`SCA_BIT_HIRQ_N];
            // events after clears: set wins
            if (hit(`SCA_ADDR_CHIP_IRQ_RD))
                next_r.low[`SCA_BIT_CHIP_N] = 1'b1;
            if (chip_irq)
                next_r.low[`SCA_BIT_CHIP_N] = 1'b0;
            if (clr(`SCA_BIT_NMI_N))
                next_r.low[`SCA_BIT_NMI_N] = 1'b1;
            if (dma_fault)
                next_r.low[`SCA_BIT_NMI_N] = 1'b0;
            if (clr(`SCA_BIT_EOPB_N))
                next_r.low[`SCA_BIT_EOPB_N] = 1'b1;
            if (eop_b)
                next_r.low[`SCA_BIT_EOPB_N] = 1'b0;
            if (clr(`SCA_BIT_EOPA_N))
                next_r.low[`SCA_BIT_EOPA_N] = 1'b1;
            if (eop_a)
                next_r.low[`SCA_BIT_EOPA_N] = 1'b0;
            if (clr(`SCA_BIT_BRST_N))
                next_r.low[`SCA_BIT_BRST_N] = 1'b1;
            if (scsi_rst_detect)
                next_r.low[`SCA_BIT_BRST_N] = 1'b0;
            if (clr(`SCA_BIT_ATTN))
                next_r.low[`SCA_BIT_ATTN] = 1'b0;
            if (sys_ctrl_access)
                next_r.low[`SCA_BIT_ATTN] = 1'b1;
            if (clr(`SCA_BIT_PRECFG))
                next_r.low[`SCA_BIT_PRECFG] = 1'b0;
            if (sys_idvec_access && !sys_iack_cycle)
                next_r.low[`SCA_BIT_PRECFG] = 1'b1;
            // local interrupt lines: nmi, three, two, one, zero
            next_r.irq = {!next_r.low[`SCA_BIT_NMI_N],
                          !next_r.low[`SCA_BIT_EOPB_N] || !next_r.low[`SCA_BIT_EOPA_N],
                          !next_r.low[`SCA_BIT_CHIP_N] || !next_r.low[`SCA_BIT_BRST_N],
                          next_r.low[`SCA_BIT_ATTN],
                          next_r.low[`SCA_BIT_PRECFG]};
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            r     <= '0;
            r.low <= `SCA_CSW_LOW_RST;
        end
        else
            r <= next_r;
    end

    assign lb.rdata           = r.rdata;
    assign host_irq_request_n = r.low[`SCA_BIT_HIRQ_N];
    assign local_nmi          = r.irq[4];
    assign local_irq_three    = r.irq[3];
    assign local_irq_two      = r.irq[2];
    assign local_irq_one      = r.irq[1];
    assign local_irq_zero     = r.irq[0];
    assign id_vector          = r.id_vector;
    assign local_page         = r.local_page;
    assign inbound_page       = r.in_page;
    assign outbound_page      = r.out_page;
    assign bus_reset_strobe     = r.bus_reset;
endmodule // sca_dev
`default_nettype wire

// ==== tb/sca_local_sva.sv ====
// local bus assertions
`default_nettype none
module sca_local_sva (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [15:0] la;
    logic [1:0]  ptr;
    wire logic   srd = rd && addr == 16'h0484;
    // last address and pointer model
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
            {la, ptr} <= 18'h0;
        else if (wr || rd)
            {la, ptr} <= {addr, addr != 16'h0580 && (ptr[1] ^ (wr && addr == 16'h0608)),
                          addr != 16'h0500 && (ptr[0] ^ (rd && addr == 16'h0608))};
    a_one_strobe: assert property (!(wr && rd)) else $error("strobes");
    a_rdata_idle: assert property (!rd |=> rdata == 16'h0) else $error("idle");
    a_wptr_track: assert property (srd |=> rdata[15] == ptr[1]) else $error("wptr");
    a_rptr_track: assert property (srd |=> rdata[14] == ptr[0]) else $error("rptr");
    a_irq_negate: assert property (srd&&la==16'h048f |=> rdata[7]) else $error("b7");
    a_chip_clear: assert property (srd&&la==16'h040d |=> rdata[6]) else $error("b6");
    a_nmi_clear: assert property (srd&&la==16'h048d |=> rdata[5]) else $error("b5");
    a_attn_off: assert property (srd&&la==16'h0489 |=> !rdata[1]) else $error("b1");
    a_flush_empty: assert property (srd && la == 16'h0500 |=> rdata[14:13] == 2'b01)
        else $error("flush");
    a_init_clear: assert property ($fell(rst) |-> ##[1:3] (wr && addr == 16'h0488)
        ##1 (wr && addr == 16'h0489 && wdata == 16'h0)) else $error("init");
    c_flush: cover property (srd && la == 16'h0500);
    c_byte_wr: cover property (wr && addr == 16'h0608);
    c_word_rd: cover property (rd && addr == 16'h0600);
endmodule // sca_local_sva
`default_nettype wire

// ==== tb/scsi_adapter_ctrl_status_regs_bench.sv ====
// self-checking bench of both ends
`default_nettype none
module scsi_adapter_ctrl_status_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  sw_addr = 4'h0;
    logic [15:0] sw_wdata = 16'h0;
    logic        sw_wr = 1'b0;
    logic        sw_rd = 1'b0;
    logic [8:0]  ev = 9'h0;
    logic [15:0] rv, st, res, pv[5];
    logic [15:0] pa[5] = '{16'h0480, 16'h0482, 16'h04a2, 16'h04c2, 16'h0486};
    int          bt[8] = '{5, 3, 4, 2, 6, 1, 0, 0};
    wire logic [15:0] sw_rdata, idv;
    wire logic [6:0]  lpg, ipg, opg;
    wire logic [5:0]  io;
    wire logic        sbr;
    logic [7:0]  lo = 8'hfc;
    logic [7:0]  fq[2][$];
    logic        wp = 1'b0, rp = 1'b0;
    logic [31:0] seed = 32'd74664;
    int          i, n_fail = 0, check_count = 0;
    sca_local_if lb ();
    always #10 clk_sys = ~clk_sys;
    sca_host sca_host_i (.clk_sys, .rst, .ce(1'b1), .sw_addr, .sw_wdata, .sw_wr, .sw_rd,
        .sw_rdata, .lb(lb.host));
    sca_dev #(.FIFO_DEPTH(4)) sca_dev_i (.clk_sys, .rst, .ce(1'b1), .dma_fault(ev[0]),
        .eop_a(ev[1]), .eop_b(ev[2]), .scsi_rst_detect(ev[3]), .chip_irq(ev[4]),
        .sys_ctrl_access(ev[5]), .sys_idvec_access(ev[6]), .sys_iack_cycle(ev[7]),
        .interrupt_ack_strobe(ev[8]), .host_irq_request_n(io[0]), .local_irq_zero(io[1]),
        .local_irq_one(io[2]), .local_irq_two(io[3]), .local_irq_three(io[4]),
        .local_nmi(io[5]), .id_vector(idv), .local_page(lpg), .inbound_page(ipg),
        .outbound_page(opg), .bus_reset_strobe(sbr), .lb(lb.dev));
    sca_local_sva sca_local_sva_i (.clk_sys, .rst, .addr(lb.addr), .wdata(lb.wdata),
        .wr(lb.wr), .rd(lb.rd), .rdata(lb.rdata));
    function logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task sw(input logic [3:0] a, input logic [15:0] d, input logic w);
        @(posedge clk_sys);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= w;
        sw_rd <= !w;
        @(posedge clk_sys);
        sw_wr <= 1'b0;
        sw_rd <= 1'b0;
        @(posedge clk_sys);
        rv = sw_rdata;
    endtask
    task idle();
        rv = 16'h1;
        for (int k = 0; k < 40 && rv[0] !== 1'b0; k++)
            sw(4'h3, 16'h0, 1'b0);
        st = rv;
        if (rv[0] !== 1'b0)
        begin
            cmp("busy", 16'h0, rv);
            end_sim();
        end
    endtask
    task cmd(input logic [2:0] op, input logic [15:0] a, input logic [15:0] d);
        sw(4'h1, a, 1'b1);
        sw(4'h2, d, 1'b1);
        sw(4'h0, {13'h0, op}, 1'b1);
        idle();
        sw(4'h2, 16'h0, 1'b0);
        res = rv;
    endtask
    task chk();
        cmd(3'h1, 16'h0484, 16'h0);
        cmp("status", {wp, rp, fq[rp].size() == 0, fq[wp].size() == 4, fq[1].size() != 4,
            fq[0].size() != 4, fq[1].size() != 0, fq[0].size() != 0, lo}, res);
        cmp("irq", {10'h0,~lo[5],~lo[4]|~lo[3],~lo[6]|~lo[2],lo[1:0],lo[7]}, 16'(io));
    endtask
    task fop(input logic [2:0] op);
        logic [15:0] d, e;
        logic        f;
        d = rnd();
        e = 16'h0;
        f = op == 3'h2 ? fq[0].size() == 4 || fq[1].size() == 4 :
            op == 3'h3 ? fq[0].size() == 0 || fq[1].size() == 0 :
            op == 3'h4 ? fq[wp].size() == 4 : fq[rp].size() == 0;
        cmd(op, 16'h0, d);
        cmp("refused", {15'h0, f}, {15'h0, st[2]});
        for (int j = 0; j < 2 && !f && op == 3'h2; j++)
            fq[j].push_back(d[8*j+:8]);
        if (!f && op == 3'h3)
            e = {fq[1].pop_front(), fq[0].pop_front()};
        if (!f && op == 3'h4)
            fq[wp].push_back(d[7:0]);
        if (!f && op == 3'h5)
            e = {8'h0, fq[rp].pop_front()};
        wp = wp ^ (!f && op == 3'h4);
        rp = rp ^ (!f && op == 3'h5);
        if (!f && op[0])
            cmp("fifo", e, op[2] ? {8'h0, res[7:0]} : res);
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        idle();
        chk();
        for (i = 0; i < 8; i++)
        begin
            @(posedge clk_sys);
            ev <= i < 7 ? 9'(1 << i) : 9'h0c0;
            @(posedge clk_sys);
            ev <= 9'h0;
            lo[bt[i]] = i < 7 ? bt[i] < 2 : lo[bt[i]];
            chk();
            cmd(3'h1, bt[i] == 6 ? 16'h040d : 16'h0488 + 16'(bt[i]), 16'h0);
            lo[bt[i]] = bt[i] > 1;
            chk();
        end
        ev <= 9'h008;
        lo[2] = 1'b0;
        cmd(3'h1, 16'h048a, 16'h0);
        chk();
        ev <= 9'h0;
        cmd(3'h1, 16'h048a, 16'h0);
        lo[2] = 1'b1;
        cmd(3'h0, 16'h0484, 16'h0);
        lo[7] = 1'b0;
        chk();
        ev <= 9'h100;
        @(posedge clk_sys);
        ev <= 9'h0;
        lo[7] = 1'b1;
        chk();
        cmd(3'h0, 16'h0484, 16'h0);
        cmd(3'h1, 16'h048f, 16'h0);
        chk();
        $display("test flags done");
        for (i = 0; i < 5; i++)
        begin
            pv[i] = rnd();
            cmd(3'h0, pa[i], pv[i]);
        end
        cmp("id_vector", pv[0], idv);
        cmp("pages", {2'h0, pv[1][6:0], pv[2][6:0]}, {2'h0, lpg, ipg});
        cmp("out_page", {8'h0, pv[3][6:0], pv[4][0]}, {8'h0, opg, sbr});
        cmd(3'h1, 16'h0700, 16'h0);
        cmp("unmapped", 16'h0, res);
        $display("test regs done");
        repeat (5) fop(3'h2);
        chk();
        repeat (5) fop(3'h3);
        repeat (9) fop(3'h4);
        chk();
        repeat (9) fop(3'h5);
        repeat (3) fop(3'h4);
        fop(3'h5);
        cmd(3'h1, 16'h0500, 16'h0);
        fq[0].delete();
        fq[1].delete();
        rp = 1'b0;
        chk();
        cmd(3'h1, 16'h0580, 16'h0);
        wp = 1'b0;
        chk();
        repeat (30) fop(3'h2 + 3'(rnd() & 16'h3));
        chk();
        $display("test fifo done");
        end_sim();
    end
endmodule // scsi_adapter_ctrl_status_regs_bench
`default_nettype wire
